// file: rtl/ssd_consts.svh
// constants for the synchronous dram command core: timing, mode fields, resets
// assumes a 100 MHz core clock; included by bare name from the fifo, bank and core files
//
// Behaviour
// - command decoded from row, column, write strobes
// - read: bank from bank select, burst from column
// - read with precharge select closes row after burst
// - precharge select low keeps accessed row open
// - read byte gated by mask two clocks earlier
// - write: bank from bank select, burst from column
// - write with precharge select closes row after burst
// - write byte stored only where its mask low
// - precharge closes one bank or all banks
// - auto precharge chosen per read or write
// - auto precharge starts at earliest burst point
// - activated row stays open until precharged
// - chip select high ignores commands, running burst continues
`ifndef SSD_CONSTS_SVH
`define SSD_CONSTS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSD_CLK_PERIOD_NS       10
`define SSD_PRECHARGE_PERIOD_NS 15
`define SSD_TRP_CYC ((`SSD_PRECHARGE_PERIOD_NS + `SSD_CLK_PERIOD_NS - 1) / `SSD_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// address and mode fields
// ----------------------------------------------------------------
`define SSD_AP_BIT      10
`define SSD_MR_BL_LSB   0
`define SSD_MR_CL_LSB   4
`define SSD_BL_FULL     3'h7
`define SSD_CL_THREE    3'h3
`define SSD_MODE_BL_RST 3'h2
`define SSD_MODE_CL_RST 3'h2

`endif

// file: rtl/ssd_pkg.sv
// types shared by the dram command core and its bank trackers
// assumes nothing beyond a SystemVerilog compiler
package ssd_pkg;

    // command code is {row strobe, column strobe, write strobe}, all active low
    typedef enum logic [2:0] {
        SSD_CMD_MRS = 3'b000,
        SSD_CMD_REF = 3'b001,
        SSD_CMD_PRE = 3'b010,
        SSD_CMD_ACT = 3'b011,
        SSD_CMD_WR  = 3'b100,
        SSD_CMD_RD  = 3'b101,
        SSD_CMD_BST = 3'b110,
        SSD_CMD_NOP = 3'b111
    } ssd_cmd_t;

    typedef enum logic [1:0] {
        SSD_BK_IDLE  = 2'b00,
        SSD_BK_OPEN  = 2'b01,
        SSD_BK_PRECH = 2'b10
    } ssd_bank_st_t;

endpackage : ssd_pkg

// file: rtl/ssd_fifo.sv
// small synchronous fifo, valid/ready on both sides
// assumes one clock, synchronous active-low reset, clock enable freezing state
`include "ssd_consts.svh"
module ssd_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // clocking
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    // fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("ssd_fifo: depth must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    wire              push = in_valid & in_ready & ce;
    wire              pop  = out_valid & out_ready & ce;

    assign in_ready  = cnt_r != (AW+1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data  = mem[rp_r];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_r + AW'(push);
            rp_r  <= rp_r + AW'(pop);
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // full is derived from the count, so check the word path instead
    property p_fifo_pass;
        (cnt_r == '0 && push) |=> out_valid && out_data == $past(in_data);
    endproperty
    a_fifo_pass : assert property (p_fifo_pass) else $error("first word not presented");

endmodule : ssd_fifo

// file: rtl/ssd_bank.sv
// one bank's row state: idle, open with a row, or precharging
// assumes command pulses are already qualified by chip select and clock enable
`include "ssd_consts.svh"
module ssd_bank
    import ssd_pkg::*;
#(
    parameter int ROW_BITS = 12,
    parameter int TRP_CYC  = `SSD_TRP_CYC
) (
    // clocking
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                ce,
    // commands for this bank
    input  wire logic                act,
    input  wire logic [ROW_BITS-1:0] row_in,
    input  wire logic                pre,
    input  wire logic                ap_fire,
    // state
    output logic                     open,
    output logic [ROW_BITS-1:0]      row
);
    localparam int CW = $clog2(TRP_CYC + 1);

    if (TRP_CYC < 1) begin : g_chk
        $error("ssd_bank: precharge period must be at least one cycle");
    end

    ssd_bank_st_t  st_r;
    ssd_bank_st_t  st_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic [ROW_BITS-1:0] row_r;

    assign open = st_r == SSD_BK_OPEN;
    assign row  = row_r;

    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        unique case (st_r)
            SSD_BK_IDLE: begin
                if (act) begin
                    st_nxt = SSD_BK_OPEN;
                end
            end
            SSD_BK_OPEN: begin
                if (pre || ap_fire) begin
                    st_nxt  = SSD_BK_PRECH;
                    cnt_nxt = CW'(TRP_CYC - 1);
                end
            end
            SSD_BK_PRECH: begin
                // activations during the precharge period are dropped
                if (cnt_r == '0) begin
                    st_nxt = SSD_BK_IDLE;
                end else begin
                    cnt_nxt = cnt_r - CW'(1);
                end
            end
            default: st_nxt = SSD_BK_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_r  <= SSD_BK_IDLE;
            cnt_r <= '0;
            row_r <= '0;
        end else if (ce) begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            if (st_r == SSD_BK_IDLE && act) begin
                row_r <= row_in;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_act_open;
        (ce && act && st_r == SSD_BK_IDLE) |=> open && row == $past(row_in);
    endproperty
    a_act_open : assert property (p_act_open) else $error("activate did not open row");

    property p_open_holds;
        (open && !pre && !ap_fire) |=> open;
    endproperty
    a_open_holds : assert property (p_open_holds) else $error("open row closed without precharge");

endmodule : ssd_bank

// file: rtl/ssd_sdram.sv
// synchronous dram core: command decode, four banks, burst engine, array,
// masked read pipeline and buffered write path
// assumes commands arrive synchronous to CORE_CLK; data pins split in/out/enable
`include "ssd_consts.svh"
module ssd_sdram
    import ssd_pkg::*;
#(
    parameter int ROW_BITS   = 12,
    parameter int COL_BITS   = 9,
    parameter int DATA_W     = 16,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input  wire logic                CORE_CLK,
    input  wire logic                RSTN,
    input  wire logic                CLK_EN,
    // command
    input  wire logic                CS_N,
    input  wire logic                RAS_N,
    input  wire logic                CAS_N,
    input  wire logic                WE_N,
    input  wire logic                BANK_SELECT_0,
    input  wire logic                BANK_SELECT_1,
    input  wire logic [11:0]         ADDR,
    // byte masks
    input  wire logic                LOW_BYTE_MASK,
    input  wire logic                HIGH_BYTE_MASK,
    // data pins
    input  wire logic [DATA_W-1:0]   DQ_IN,
    output logic      [DATA_W-1:0]   DQ_OUT,
    output logic      [1:0]          DQ_OE,
    // write buffer status
    output logic                     WR_BUF_RDY
);
    localparam int AW = 2 + ROW_BITS + COL_BITS;
    localparam int EW = AW + 2 + DATA_W;

    if (DATA_W != 16 || COL_BITS < 3 || COL_BITS > 10 || ROW_BITS < 1 || ROW_BITS > 12) begin : g_chk
        $error("ssd_sdram: unsupported geometry");
    end

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    ssd_cmd_t  cmd_w;
    wire       cmd_vld = CLK_EN & ~CS_N;
    wire [1:0] bsel    = {BANK_SELECT_1, BANK_SELECT_0};
    wire [1:0] mask_w  = {HIGH_BYTE_MASK, LOW_BYTE_MASK};
    wire       ap_sel  = ADDR[`SSD_AP_BIT];
    logic [3:0] bank_open_w;
    logic [ROW_BITS-1:0] bank_row_w [4];

    assign cmd_w = ssd_cmd_t'({RAS_N, CAS_N, WE_N});

    wire act_ok  = cmd_vld & (cmd_w == SSD_CMD_ACT);
    wire pre_ok  = cmd_vld & (cmd_w == SSD_CMD_PRE);
    wire bst_ok  = cmd_vld & (cmd_w == SSD_CMD_BST);
    wire mrs_ok  = cmd_vld & (cmd_w == SSD_CMD_MRS) & (bsel == 2'h0) & ~ap_sel;
    wire rd_cmd  = cmd_vld & (cmd_w == SSD_CMD_RD);
    wire wr_cmd  = cmd_vld & (cmd_w == SSD_CMD_WR);
    // read or write to an idle bank is ignored
    wire rdwr_ok = (rd_cmd | wr_cmd) & bank_open_w[bsel];
    wire rd_ok   = rd_cmd & bank_open_w[bsel];
    wire wr_ok   = wr_cmd & bank_open_w[bsel];

    // ----------------------------------------------------------------
    // mode setting
    // ----------------------------------------------------------------
    logic [2:0] mode_bl_r;
    logic [2:0] mode_cl_r;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            mode_bl_r <= `SSD_MODE_BL_RST;
            mode_cl_r <= `SSD_MODE_CL_RST;
        end else if (mrs_ok) begin
            mode_bl_r <= ADDR[`SSD_MR_BL_LSB +: 3];
            mode_cl_r <= ADDR[`SSD_MR_CL_LSB +: 3];
        end
    end

    wire full_pg = mode_bl_r == `SSD_BL_FULL;
    wire cl3     = mode_cl_r == `SSD_CL_THREE;
    // wrap mask inside the burst; reserved codes fall back to short bursts
    wire [COL_BITS-1:0] bl_mask = full_pg ? {COL_BITS{1'b1}}
                                          : COL_BITS'((10'h1 << mode_bl_r[1:0]) - 10'h1);

    // ----------------------------------------------------------------
    // burst engine
    // ----------------------------------------------------------------
    logic                burst_act_r;
    logic                burst_wr_r;
    logic                burst_ap_r;
    logic [1:0]          burst_bank_r;
    logic [COL_BITS-1:0] burst_col_r;
    logic [COL_BITS-1:0] burst_left_r;

    wire                beat_go   = rdwr_ok | burst_act_r;
    wire                beat_wr   = rdwr_ok ? wr_cmd : burst_wr_r;
    wire [1:0]          beat_bank = rdwr_ok ? bsel : burst_bank_r;
    wire [COL_BITS-1:0] beat_col  = rdwr_ok ? ADDR[COL_BITS-1:0] : burst_col_r;
    wire [COL_BITS-1:0] col_inc   = beat_col + COL_BITS'(1);
    wire [COL_BITS-1:0] col_nxt   = (beat_col & ~bl_mask) | (col_inc & bl_mask);
    wire                last_w    = beat_go & ~full_pg
                                  & (rdwr_ok ? (bl_mask == '0) : (burst_left_r == '0));
    // precharge select is taken from each command on its own
    wire                ap_now    = rdwr_ok ? ap_sel : burst_ap_r;
    // close the row in the cycle of the last beat, the earliest safe point
    wire                ap_fire   = last_w & ap_now;
    wire                pre_hit   = pre_ok & (ap_sel | (bsel == burst_bank_r));
    wire                burst_end = last_w | bst_ok | pre_hit;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            burst_act_r  <= 1'b0;
            burst_wr_r   <= 1'b0;
            burst_ap_r   <= 1'b0;
            burst_bank_r <= 2'h0;
            burst_col_r  <= '0;
            burst_left_r <= '0;
        end else if (CLK_EN) begin
            if (rdwr_ok) begin
                // a new access cuts the running burst short
                burst_act_r  <= ~last_w;
                burst_wr_r   <= wr_cmd;
                burst_ap_r   <= ap_sel;
                burst_bank_r <= bsel;
                burst_col_r  <= col_nxt;
                burst_left_r <= bl_mask - COL_BITS'(1);
            end else if (burst_act_r) begin
                burst_act_r  <= ~burst_end;
                burst_col_r  <= col_nxt;
                burst_left_r <= burst_left_r - COL_BITS'(1);
            end
        end
    end

    // ----------------------------------------------------------------
    // banks
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 4; g++) begin : g_bank
        ssd_bank #(
            .ROW_BITS (ROW_BITS),
            .TRP_CYC  (`SSD_TRP_CYC)
        ) u_bank (
            .clk     (CORE_CLK),
            .rstn    (RSTN),
            .ce      (CLK_EN),
            .act     (act_ok & (bsel == 2'(g))),
            .row_in  (ADDR[ROW_BITS-1:0]),
            .pre     (pre_ok & (ap_sel | (bsel == 2'(g)))),
            .ap_fire (ap_fire & (beat_bank == 2'(g))),
            .open    (bank_open_w[g]),
            .row     (bank_row_w[g])
        );
    end

    // ----------------------------------------------------------------
    // write buffer
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] mem [2**AW];
    wire  [AW-1:0]     beat_addr = {beat_bank, bank_row_w[beat_bank], beat_col};
    wire               wr_push   = beat_go & beat_wr;
    wire               rd_beat   = beat_go & ~beat_wr;
    logic              fifo_in_rdy;
    logic              fifo_out_vld;
    logic [EW-1:0]     fifo_out;

    // the array has one port; a read beat stalls the drain so the buffer holds its word
    wire               drain_rdy = ~rd_beat;
    wire               drain     = fifo_out_vld & drain_rdy & CLK_EN;
    wire  [AW-1:0]     drain_addr = fifo_out[EW-1 -: AW];
    wire  [1:0]        drain_mask = fifo_out[DATA_W +: 2];
    wire  [DATA_W-1:0] drain_data = fifo_out[DATA_W-1:0];

    ssd_fifo #(
        .WIDTH (EW),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk       (CORE_CLK),
        .rstn      (RSTN),
        .ce        (CLK_EN),
        .in_valid  (wr_push),
        .in_data   ({beat_addr, mask_w, DQ_IN}),
        .in_ready  (fifo_in_rdy),
        .out_valid (fifo_out_vld),
        .out_ready (drain_rdy),
        .out_data  (fifo_out)
    );

    // ----------------------------------------------------------------
    // array
    // ----------------------------------------------------------------
    // limitation: a read of a word still waiting in the buffer returns old data
    always_ff @(posedge CORE_CLK) begin
        if (drain && !drain_mask[0]) begin
            mem[drain_addr][7:0] <= drain_data[7:0];
        end
        if (drain && !drain_mask[1]) begin
            mem[drain_addr][15:8] <= drain_data[15:8];
        end
    end

    // ----------------------------------------------------------------
    // read pipeline and output masking
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] rd_q_r;
    logic [DATA_W-1:0] rd_p1_r;
    logic [DATA_W-1:0] rd_p2_r;
    logic [2:0]        rd_v_r;
    logic [1:0]        mask_d1_r;
    logic [1:0]        mask_d2_r;

    always_ff @(posedge CORE_CLK) begin
        if (CLK_EN && rd_beat) begin
            rd_q_r <= mem[beat_addr];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            rd_p1_r <= '0;
            rd_p2_r <= '0;
            rd_v_r  <= 3'h0;
        end else if (CLK_EN) begin
            rd_p1_r <= rd_q_r;
            rd_p2_r <= rd_p1_r;
            rd_v_r  <= {rd_v_r[1:0], rd_beat};
        end
    end

    wire               out_vld = cl3 ? rd_v_r[2] : rd_v_r[1];
    wire [DATA_W-1:0]  out_dat = cl3 ? rd_p2_r : rd_p1_r;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            mask_d1_r  <= 2'h3;
            mask_d2_r  <= 2'h3;
            DQ_OUT     <= '0;
            DQ_OE      <= 2'h0;
            WR_BUF_RDY <= 1'b0;
        end else if (CLK_EN) begin
            mask_d1_r  <= mask_w;
            mask_d2_r  <= mask_d1_r;
            DQ_OUT     <= out_dat;
            DQ_OE      <= {2{out_vld}} & ~mask_d2_r;
            WR_BUF_RDY <= fifo_in_rdy;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    sequence s_mask_lo_hi;
        CLK_EN && LOW_BYTE_MASK ##1 CLK_EN [*2];
    endsequence
    property p_mask_off;
        s_mask_lo_hi |=> !DQ_OE[0];
    endproperty
    a_mask_off : assert property (p_mask_off) else $error("masked byte driven");

    sequence s_rd_cl2;
        rd_ok && mode_cl_r == 3'h2 && mask_w == 2'h0 ##1 CLK_EN [*2];
    endsequence
    property p_rd_data;
        s_rd_cl2 |=> DQ_OE == 2'h3;
    endproperty
    a_rd_data : assert property (p_rd_data) else $error("read data not driven at latency");

    property p_cs_hold;
        (CS_N && !burst_act_r) |=> $stable(bank_open_w);
    endproperty
    a_cs_hold : assert property (p_cs_hold) else $error("state changed while deselected");

    property p_rd_ap_bl1;
        (rd_ok && ap_sel && mode_bl_r == 3'h0) |=> !bank_open_w[$past(bsel)];
    endproperty
    a_rd_ap_bl1 : assert property (p_rd_ap_bl1) else $error("read auto precharge missed");

    sequence s_rd_ap_bl2;
        rd_ok && ap_sel && mode_bl_r == 3'h1 ##1 CLK_EN && !rdwr_ok && !pre_ok && !bst_ok;
    endsequence
    property p_rd_ap_bl2;
        s_rd_ap_bl2 |=> !bank_open_w[burst_bank_r];
    endproperty
    a_rd_ap_bl2 : assert property (p_rd_ap_bl2) else $error("auto precharge not at last beat");

    property p_wr_ap;
        (wr_ok && ap_sel && mode_bl_r == 3'h0) |=> !bank_open_w[$past(bsel)];
    endproperty
    a_wr_ap : assert property (p_wr_ap) else $error("write auto precharge missed");

    property p_no_ap;
        (rdwr_ok && !ap_sel) |=> bank_open_w[$past(bsel)];
    endproperty
    a_no_ap : assert property (p_no_ap) else $error("row closed without auto precharge");

    property p_pre_all;
        (pre_ok && ap_sel) |=> bank_open_w == 4'h0;
    endproperty
    a_pre_all : assert property (p_pre_all) else $error("precharge all left a bank open");

    property p_pre_one;
        (pre_ok && !ap_sel) |=> !bank_open_w[$past(bsel)];
    endproperty
    a_pre_one : assert property (p_pre_one) else $error("bank precharge left row open");

    property p_wr_push;
        (wr_ok && fifo_in_rdy) |=> fifo_out_vld;
    endproperty
    a_wr_push : assert property (p_wr_push) else $error("write beat not buffered");

endmodule : ssd_sdram

// file: verif/ssd_ctl_model.sv
// memory controller model: drives command, mask and write data pins
// assumes clock from the bench; every pin changes at the falling edge
module ssd_ctl_model
    import ssd_pkg::*;
(
    // clock
    input  wire logic        clk,
    // command and data pins
    output logic             cs_n,
    output ssd_cmd_t         code,
    output logic [1:0]       bank,
    output logic [11:0]      addr,
    output logic [1:0]       mask,
    output logic [15:0]      dq,
    // read return
    input  wire logic [15:0] dq_out,
    input  wire logic [1:0]  dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    int lat = 2;

    task automatic put(input logic c, input ssd_cmd_t op, input logic [1:0] bk, input logic [11:0] a);
        cs_n = c;
        code = op;
        bank = bk;
        addr = a;
    endtask : put

    task automatic cmd(input ssd_cmd_t op, input logic [1:0] bk, input logic [11:0] a);
        @(negedge clk);
        put(1'b0, op, bk, a);
        @(negedge clk);
        put(1'b0, SSD_CMD_NOP, bk, a);
    endtask : cmd

    // ------------------------------------------------------------
    // one four-beat burst; read slots sampled lat+1 falls later
    // ------------------------------------------------------------
    task automatic burst(input logic c, input logic wr, input logic [1:0] bk, input logic [11:0] a,
                         input logic [63:0] d, input logic [7:0] m,
                         output logic [63:0] q, output logic [7:0] oe);
        for (int t = 0; t <= lat + 4; t++) begin
            // read masks lead their beat by two clocks, so they shift with latency
            int k;
            k = wr ? t : t - lat + 2;
            @(negedge clk);
            put((t == 0) ? c : 1'b0, (t == 0) ? (wr ? SSD_CMD_WR : SSD_CMD_RD) : SSD_CMD_NOP, bk, a);
            // idle bus toggles so a stale value never reads as good
            dq = (wr && t < 4) ? d[16*t +: 16] : ~dq;
            if (k >= 0 && k < 4) begin
                mask = m[2*k +: 2];
            end
            if (t > lat) begin
                q[16*(t-lat-1) +: 16] = dq_out;
                oe[2*(t-lat-1) +: 2] = dq_oe;
            end
        end
    endtask : burst

    initial begin
        put(1'b1, SSD_CMD_NOP, 2'b00, 12'h000);
        mask = 2'b11;
        dq = 16'h0000;
    end
endmodule : ssd_ctl_model

// file: verif/sdram_read_write_precharge_tb.sv
// self-checking bench for the dram command core
// assumes the controller model and a reduced array of 4 row and 4 column bits
module sdram_read_write_precharge_tb
    import ssd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        cs_n;
    ssd_cmd_t    code;
    logic [1:0]  bank, mask, dq_oe, e, bk;
    logic [11:0] addr;
    logic [15:0] dq, dq_out;
    logic        wr_rdy;
    logic [15:0] mem [int];
    logic [63:0] d, q;
    logic [7:0]  m, oe;
    logic [3:0]  row, col;
    int          seed = 86;
    int          cyc = 0;
    int          bad_count = 0;
    int          compares = 0;

    always #5 core_clk = ~core_clk;

    ssd_ctl_model ctl (.clk(core_clk), .cs_n(cs_n), .code(code), .bank(bank), .addr(addr),
                       .mask(mask), .dq(dq), .dq_out(dq_out), .dq_oe(dq_oe));

    ssd_sdram #(.ROW_BITS(4), .COL_BITS(4)) dut (
        .CORE_CLK(core_clk), .RSTN(rstn), .CLK_EN(1'b1), .CS_N(cs_n),
        .RAS_N(code[2]), .CAS_N(code[1]), .WE_N(code[0]),
        .BANK_SELECT_0(bank[0]), .BANK_SELECT_1(bank[1]), .ADDR(addr),
        .LOW_BYTE_MASK(mask[0]), .HIGH_BYTE_MASK(mask[1]), .DQ_IN(dq),
        .DQ_OUT(dq_out), .DQ_OE(dq_oe), .WR_BUF_RDY(wr_rdy));

    // ------------------------------------------------------------
    // expectation helpers
    // ------------------------------------------------------------
    function automatic int key(logic [1:0] b, logic [3:0] r, logic [3:0] c, int i);
        return {b, r, c[3:2], c[1:0] + 2'(i)};
    endfunction : key

    function automatic logic [15:0] bytes(logic [1:0] en);
        return {{8{en[1]}}, {8{en[0]}}};
    endfunction : bytes

    task automatic stop_test();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_burst(input logic ap, input int nb);
        d = {$random(seed), $random(seed)};
        ctl.burst(1'b0, 1'b1, bk, {1'b0, ap, 6'h00, col}, d, m, q, oe);
        for (int i = 0; i < nb; i++) begin
            mem[key(bk, row, col, i)] = (mem[key(bk, row, col, i)] & bytes(m[2*i +: 2]))
                                      | (d[16*i +: 16] & ~bytes(m[2*i +: 2]));
        end
        // buffered words must drain before they are read back
        repeat (12) @(negedge core_clk);
    endtask : wr_burst

    task automatic rd_burst(input logic c, input logic ap, input int nb, input logic live);
        m = 8'($random(seed));
        ctl.burst(c, 1'b0, bk, {1'b0, ap, 6'h00, col}, 64'h0, m, q, oe);
        for (int i = 0; i < 4; i++) begin
            e = (live && i < nb) ? ~m[2*i +: 2] : 2'b00;
            check({14'h0000, oe[2*i +: 2]}, {14'h0000, e});
            check(q[16*i +: 16] & bytes(e), mem[key(bk, row, col, i)] & bytes(e));
        end
    endtask : rd_burst

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            bad_count++;
            stop_test();
        end
    end

    initial begin
        repeat (20) @(negedge core_clk);
        rstn = 1'b1;
        @(negedge core_clk);
        check({15'h0000, wr_rdy}, 16'h0001);
        for (int it = 0; it < 16; it++) begin
            bk = 2'($random(seed));
            row = 4'($random(seed));
            col = 4'($random(seed));
            ctl.cmd(SSD_CMD_ACT, bk, {8'h00, row});
            m = 8'h00;
            wr_burst(it[0], 4);
            if (it[0]) begin
                rd_burst(1'b0, 1'b0, 4, 1'b0);
                ctl.cmd(SSD_CMD_ACT, bk, {8'h00, row});
            end
            m = 8'($random(seed));
            wr_burst(1'b0, 4);
            rd_burst(1'b1, 1'b0, 4, 1'b0);
            rd_burst(1'b0, it[1], 4, 1'b1);
            if (!it[1]) begin
                ctl.cmd(SSD_CMD_PRE, bk, {1'b0, it[2], 10'h000});
            end
            repeat (3) @(negedge core_clk);
            rd_burst(1'b0, 1'b0, 4, 1'b0);
        end
        // burst of two, read latency three
        ctl.cmd(SSD_CMD_MRS, 2'b00, 12'h031);
        ctl.lat = 3;
        bk = 2'b00;
        col = 4'h0;
        ctl.cmd(SSD_CMD_ACT, bk, {8'h00, row});
        m = 8'h00;
        wr_burst(1'b0, 2);
        rd_burst(1'b0, 1'b0, 2, 1'b1);
        rd_burst(1'b0, 1'b1, 2, 1'b1);
        // burst of one, read latency two: auto precharge at the only beat
        ctl.cmd(SSD_CMD_MRS, 2'b00, 12'h000);
        ctl.lat = 2;
        ctl.cmd(SSD_CMD_ACT, bk, {8'h00, row});
        wr_burst(1'b1, 1);
        rd_burst(1'b0, 1'b0, 4, 1'b0);
        ctl.cmd(SSD_CMD_ACT, bk, {8'h00, row});
        rd_burst(1'b0, 1'b1, 1, 1'b1);
        rd_burst(1'b0, 1'b0, 4, 1'b0);
        stop_test();
    end
endmodule : sdram_read_write_precharge_tb
